//--- clock_ctrl_defs.svh
/*
  Offsets, field positions, reset values and timing counts for the clock
  source and PLL control block. Assumes APB byte addressing, one word each.
*/
// Overview of operation
// - Internal oscillator stop bit acts only if the option byte enables it.
// - Fallback flag set keeps internal oscillator running; stop bit keeps its value.
// - Watchdog overflow during stabilization sets the fallback flag; status reads 01h.
// - Clearing PLL power-on automatically clears the PLL output select bit.
// - PLL output select accepts a one only while locked, otherwise stores zero.
// - Lock status is a registered indication, not the live detector.
// - Watchdog overflow during stabilization switches the CPU to the internal clock.
`ifndef CLOCK_CTRL_DEFS_SVH
`define CLOCK_CTRL_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_OSC_MODE     8'h00
`define OFS_CLK_STATUS   8'h04
`define OFS_PLL_CTRL     8'h08
`define OFS_LOCK_STATUS  8'h0c
`define OFS_LOCKUP_SEL   8'h10
`define OFS_IRQ_STATUS   8'h14
`define OFS_IRQ_MASK     8'h18

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define OSC_STOP_BIT     0
`define FALLBACK_BIT     0
`define PLL_ON_BIT       0
`define PLL_SEL_BIT      1
`define LOCK_BIT         0
`define STABLE_BIT       1
`define IRQ_FALLBACK     0
`define IRQ_LOCK         1
`define IRQ_STABLE       2
`define IRQ_BITS         3
`define LOCKSEL_RST      2'h1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ          20
`define LOCK_TIME_US     800
`define LOCK_MIN_CYC     (`LOCK_TIME_US * `CLK_MHZ)
`define LOCK_BASE_DEF    (`LOCK_MIN_CYC / 2)
`define STAB_CYC_DEF     32768

`endif

//--- clock_ctrl_pkg.sv
/*
  Types for the clock source and PLL control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package clock_ctrl_pkg;
  typedef enum logic [2:0] {
    OSC_STAB     = 3'b001,
    OSC_MAIN     = 3'b010,
    OSC_FALLBACK = 3'b100
  } osc_phase_t;
  typedef logic [7:0]  apb_addr_t;
  typedef logic [31:0] apb_data_t;
endpackage

//--- wait_timer.sv
/*
  Loadable down counter with a registered done flag.
  Assumes load is from logic on pclk.
*/
`timescale 1ns/100ps
module wait_timer #(
  parameter int W = 20
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         done_q;
  logic         done_d;

  always_comb
  begin
    if (load)
    begin
      cnt_d  = load_val;
      done_d = 1'b0;
    end
    else
    begin
      cnt_d  = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
      done_d = (cnt_q == '0);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;
endmodule

//--- clock_source_pll_control.sv
/*
  Clock source and PLL control: main oscillator stabilization, watchdog
  fall-back to the internal oscillator, internal oscillator stop, PLL power,
  lock-gated output select, lockup wait, APB registers and one interrupt.
  Assumes watchdog_overflow comes from logic on pclk; the option pin is async.
*/
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`include "clock_ctrl_defs.svh"
module clock_source_pll_control #(
  parameter int unsigned STAB_CYC      = `STAB_CYC_DEF,
  parameter int unsigned LOCK_BASE_CYC = `LOCK_BASE_DEF,
  parameter int          LOCK_W        = 20
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      clk_en,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire clock_ctrl_pkg::apb_addr_t paddr,
  input  wire clock_ctrl_pkg::apb_data_t pwdata,
  output clock_ctrl_pkg::apb_data_t      prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      opt_osc_mode_en,
  input  wire logic                      watchdog_overflow,
  output logic                           main_osc_stable,
  output logic                           cpu_clk_internal_sel,
  output logic                           internal_osc_run,
  output logic                           pll_power_on,
  output logic                           pll_output_select,
  output logic                           irq
);
  import clock_ctrl_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  osc_phase_t            phase_q, phase_d;
  logic [1:0]            ld_cnt_q, ld_cnt_d;
  logic                  opt_meta_q, opt_sync_q;
  logic                  opt_q, opt_d;
  logic                  stop_q, stop_d;
  logic                  on_q, on_d;
  logic                  sel_q, sel_d;
  logic [1:0]            locksel_q, locksel_d;
  logic [`IRQ_BITS-1:0]  ists_q, ists_d;
  logic [`IRQ_BITS-1:0]  imask_q, imask_d;
  logic [`IRQ_BITS-1:0]  events;
  logic                  lock_seen_q;
  logic                  fallback_q, fallback_d;
  logic                  stable_q, stable_d;
  logic                  run_q, run_d;
  logic                  irq_q, irq_d;
  apb_data_t             rdata_q, rdata_d;
  logic                  ready_q, ready_d;
  logic                  err_q, err_d;
  logic                  stab_done;
  logic                  lock_q;
  logic                  wr_fire;
  logic [LOCK_W-1:0]     lock_val;

  // ----------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------
  wait_timer #(.W(LOCK_W)) u_stab (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .load     (ld_cnt_q == 2'h0),
    .load_val (LOCK_W'(STAB_CYC)),
    .done     (stab_done)
  );

  // Power-off reloads, so the wait restarts and lock drops together
  assign lock_val = LOCK_W'(LOCK_BASE_CYC) << locksel_q;
  wait_timer #(.W(LOCK_W)) u_lock (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .load     (!on_d),
    .load_val (lock_val),
    .done     (lock_q)
  );

  // ----------------------------------------------------------------------
  // Oscillator phase
  // ----------------------------------------------------------------------
  always_comb
  begin
    phase_d = phase_q;
    case (phase_q)
      OSC_STAB:
      begin
        if (watchdog_overflow)
          phase_d = OSC_FALLBACK;
        else if (stab_done)
          phase_d = OSC_MAIN;
      end
      OSC_MAIN:     phase_d = OSC_MAIN;
      OSC_FALLBACK: phase_d = OSC_FALLBACK;
      default:      phase_d = OSC_STAB;
    endcase
    ld_cnt_d   = (ld_cnt_q == 2'h3) ? ld_cnt_q : ld_cnt_q + 2'h1;
    // Option level caught once, after it has crossed the synchroniser
    opt_d      = (ld_cnt_q == 2'h3) ? opt_q : opt_sync_q;
    fallback_d = (phase_d == OSC_FALLBACK);
    stable_d   = (phase_d == OSC_MAIN);
  end

  // ----------------------------------------------------------------------
  // APB slave and register writes
  // ----------------------------------------------------------------------
  // One wait state: pready rises in the second access cycle
  assign wr_fire = psel && penable && ready_q && pwrite;

  always_comb
  begin
    stop_d    = stop_q;
    on_d      = on_q;
    sel_d     = sel_q;
    locksel_d = locksel_q;
    imask_d   = imask_q;
    ists_d    = ists_q;
    if (wr_fire)
    begin
      case (paddr)
        // Stop bit keeps its written value even while fallback holds run
        `OFS_OSC_MODE:   stop_d = pwdata[`OSC_STOP_BIT];
        `OFS_PLL_CTRL:
        begin
          on_d  = pwdata[`PLL_ON_BIT];
          sel_d = pwdata[`PLL_SEL_BIT] && lock_q && pwdata[`PLL_ON_BIT];
        end
        `OFS_LOCKUP_SEL: locksel_d = pwdata[1:0];
        `OFS_IRQ_MASK:   imask_d = pwdata[`IRQ_BITS-1:0];
        `OFS_IRQ_STATUS: ists_d = ists_q & ~pwdata[`IRQ_BITS-1:0];
        default:         stop_d = stop_q;
      endcase
    end
    events = '0;
    events[`IRQ_FALLBACK] = fallback_d && !fallback_q;
    events[`IRQ_LOCK]     = lock_q && !lock_seen_q;
    events[`IRQ_STABLE]   = stable_d && !stable_q;
    // Set wins over a same-cycle clear
    ists_d = ists_d | events;
    irq_d  = |(ists_d & imask_d);
    // Stop honoured only when the option allows, never during fallback
    run_d  = fallback_d || !(stop_d && opt_d);
  end

  always_comb
  begin
    rdata_d = rdata_q;
    err_d   = 1'b0;
    ready_d = psel && penable && !ready_q;
    if (psel && penable && !ready_q)
    begin
      rdata_d = '0;
      case (paddr)
        `OFS_OSC_MODE:    rdata_d[`OSC_STOP_BIT] = stop_q;
        `OFS_CLK_STATUS:  rdata_d[`FALLBACK_BIT] = fallback_q;
        `OFS_PLL_CTRL:
        begin
          rdata_d[`PLL_ON_BIT]  = on_q;
          rdata_d[`PLL_SEL_BIT] = sel_q;
        end
        `OFS_LOCK_STATUS:
        begin
          rdata_d[`LOCK_BIT]   = lock_q;
          rdata_d[`STABLE_BIT] = stable_q;
        end
        `OFS_LOCKUP_SEL:  rdata_d[1:0] = locksel_q;
        `OFS_IRQ_STATUS:  rdata_d[`IRQ_BITS-1:0] = ists_q;
        `OFS_IRQ_MASK:    rdata_d[`IRQ_BITS-1:0] = imask_q;
        default:          err_d = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_q     <= OSC_STAB;
      ld_cnt_q    <= 2'h0;
      opt_meta_q  <= 1'b0;
      opt_sync_q  <= 1'b0;
      opt_q       <= 1'b0;
      stop_q      <= 1'b0;
      on_q        <= 1'b0;
      sel_q       <= 1'b0;
      locksel_q   <= `LOCKSEL_RST;
      ists_q      <= '0;
      imask_q     <= '0;
      lock_seen_q <= 1'b0;
      fallback_q  <= 1'b0;
      stable_q    <= 1'b0;
      run_q       <= 1'b1;
      irq_q       <= 1'b0;
      rdata_q     <= '0;
      ready_q     <= 1'b0;
      err_q       <= 1'b0;
    end
    else if (clk_en)
    begin
      phase_q     <= phase_d;
      ld_cnt_q    <= ld_cnt_d;
      opt_meta_q  <= opt_osc_mode_en;
      opt_sync_q  <= opt_meta_q;
      opt_q       <= opt_d;
      stop_q      <= stop_d;
      on_q        <= on_d;
      sel_q       <= sel_d;
      locksel_q   <= locksel_d;
      ists_q      <= ists_d;
      imask_q     <= imask_d;
      lock_seen_q <= lock_q;
      fallback_q  <= fallback_d;
      stable_q    <= stable_d;
      run_q       <= run_d;
      irq_q       <= irq_d;
      rdata_q     <= rdata_d;
      ready_q     <= ready_d;
      err_q       <= err_d;
    end
  end

  assign prdata               = rdata_q;
  assign pready               = ready_q;
  // Error is only ever loaded together with ready, so the flop drives the pin alone
  assign pslverr              = err_q;
  assign main_osc_stable      = stable_q;
  assign cpu_clk_internal_sel = fallback_q;
  assign internal_osc_run     = run_q;
  assign pll_power_on         = on_q;
  assign pll_output_select    = sel_q;
  assign irq                  = irq_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_power_up;
    $rose(on_q);
  endsequence

  sequence s_dark_wait;
    !lock_q [*2];
  endsequence

  a_sel_needs_lock: assert property (sel_q |-> lock_q && on_q)
    else $error("output select set without lock");
  a_off_clears_sel: assert property (wr_fire && paddr == `OFS_PLL_CTRL
    && !pwdata[`PLL_ON_BIT] && clk_en |=> !on_q && !sel_q)
    else $error("power-off did not clear select");
  a_off_drops_lock: assert property (!on_q |-> !lock_q)
    else $error("lock seen while PLL off");
  a_lock_waits: assert property (s_power_up |-> s_dark_wait)
    else $error("lock came without lockup wait");
  a_lock_registered: assert property ($rose(lock_q) |-> $past(on_q))
    else $error("lock rose without prior power");
  a_fallback_set: assert property (watchdog_overflow && phase_q == OSC_STAB
    && clk_en |=> fallback_q && cpu_clk_internal_sel)
    else $error("overflow did not set fallback");
  a_fallback_runs: assert property (fallback_q |-> internal_osc_run)
    else $error("internal oscillator stopped in fallback");
  a_stop_keeps: assert property (fallback_q && stop_q && !wr_fire |=> stop_q)
    else $error("stop bit lost during fallback");
  a_opt_gates_stop: assert property (!opt_q |-> internal_osc_run)
    else $error("stop honoured without option");
  a_cpu_follows: assert property (cpu_clk_internal_sel == (phase_q == OSC_FALLBACK))
    else $error("cpu clock select disagrees with phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held two cycles");
endmodule

//--- clock_env_model.sv
/*
  Far-side model: watchdog overflow source and option byte level.
  Assumes the bench requests an overflow one pclk edge ahead.
*/
`timescale 1ns/100ps
module clock_env_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic kick,
  input  wire logic opt_level,
  output logic      watchdog_overflow,
  output logic      opt_osc_mode_en
);
  // ------------------------------------------------------------
  // Watchdog pulse and option byte
  // ------------------------------------------------------------
  // Option byte is static per run, loaded before reset release
  assign opt_osc_mode_en = opt_level;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      watchdog_overflow <= 1'b0;
    else
      watchdog_overflow <= kick;
  end
endmodule

//--- clock_source_pll_control_bench.sv
/*
  Self-checking bench for the clock source and PLL control block.
  Assumes the design's header and package compile first.
*/
`timescale 1ns/100ps
`include "clock_ctrl_defs.svh"
module clock_source_pll_control_bench;
  import clock_ctrl_pkg::*;
  logic      pclk, presetn, psel, penable, pwrite, pready, pslverr;
  apb_addr_t paddr;
  apb_data_t pwdata, prdata, rdat;
  logic      opt, kick, wd, optp, stable, sel_int, osc_run, pll_on, pll_sel, irq, err, en;
  int        n_fail, n_compared;

  clock_source_pll_control #(.STAB_CYC(8), .LOCK_BASE_CYC(4)) clock_source_pll_control_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .opt_osc_mode_en(optp), .watchdog_overflow(wd),
    .main_osc_stable(stable), .cpu_clk_internal_sel(sel_int), .internal_osc_run(osc_run),
    .pll_power_on(pll_on), .pll_output_select(pll_sel), .irq(irq));
  clock_env_model clock_env_model_inst (
    .pclk(pclk), .presetn(presetn), .kick(kick), .opt_level(opt),
    .watchdog_overflow(wd), .opt_osc_mode_en(optp));

  // ------------------------------------------------------------
  // Clock and shared tasks
  // ------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic stop_test();
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer; slave latency is not assumed
  task automatic apb(input logic w, input apb_addr_t a, input apb_data_t d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      n_fail++;
      stop_test();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input apb_addr_t a, input apb_data_t d);
    apb(1'b1, a, d);
    // Write lands at the last edge; its outputs show only from the next one
    @(posedge pclk);
  endtask

  task automatic rd(input apb_addr_t a, input apb_data_t e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rdat);
  endtask

  task automatic do_reset(input logic o);
    opt <= o;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // Waits on main_osc_stable (k=0) or cpu_clk_internal_sel (k=1)
  task automatic wait_hi(input int k);
    int i;
    for (i = 0; i < 100; i++)
    begin
      @(posedge pclk);
      if ((k == 0 ? stable : sel_int) === 1'b1)
        return;
    end
    n_fail++;
    stop_test();
  endtask

  task automatic wait_lock();
    int i;
    for (i = 0; i < 20; i++)
    begin
      apb(1'b0, `OFS_LOCK_STATUS, 32'h0);
      if (rdat[`LOCK_BIT] === 1'b1)
        return;
    end
    n_fail++;
    stop_test();
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    n_fail = 0; n_compared = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; opt = 1'b1; kick = 1'b0; en = 1'b1;
    do_reset(1'b1);
    chk("osc_run", 1, osc_run);
    rd(`OFS_OSC_MODE, 32'h0);
    rd(`OFS_PLL_CTRL, 32'h0);
    rd(`OFS_LOCKUP_SEL, 32'h1);
    rd(`OFS_IRQ_MASK, 32'h0);
    rd(8'h1c, 32'h0);
    chk("pslverr", 1, err);
    // Software waits for a stable main clock before using it
    wait_hi(0);
    rd(`OFS_LOCK_STATUS, 32'h2);
    rd(`OFS_IRQ_STATUS, 32'h4);
    wr(`OFS_IRQ_STATUS, 32'h4);
    rd(`OFS_IRQ_STATUS, 32'h0);
    wr(`OFS_LOCKUP_SEL, 32'h1);
    wr(`OFS_PLL_CTRL, 32'h3);
    rd(`OFS_PLL_CTRL, 32'h1);
    rd(`OFS_LOCK_STATUS, 32'h2);
    chk("pll_on", 1, pll_on);
    wait_lock();
    wr(`OFS_IRQ_MASK, 32'h2);
    chk("irq", 1, irq);
    wr(`OFS_IRQ_STATUS, 32'h2);
    chk("irq", 0, irq);
    wr(`OFS_PLL_CTRL, 32'h3);
    rd(`OFS_PLL_CTRL, 32'h3);
    chk("pll_sel", 1, pll_sel);
    wr(`OFS_PLL_CTRL, 32'h2);
    rd(`OFS_PLL_CTRL, 32'h0);
    chk("pll_sel", 0, pll_sel);
    rd(`OFS_LOCK_STATUS, 32'h2);
    wr(`OFS_PLL_CTRL, 32'h1);
    rd(`OFS_LOCK_STATUS, 32'h2);
    wait_lock();
    // Stop only while not on the fall-back clock
    wr(`OFS_OSC_MODE, 32'h1);
    chk("osc_run", 0, osc_run);
    wr(`OFS_OSC_MODE, 32'h0);
    chk("osc_run", 1, osc_run);
    // Option byte off: stop bit has no effect
    do_reset(1'b0);
    // Enable low freezes the stabilization wait
    en <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("stable", 0, stable);
    en <= 1'b1;
    wait_hi(0);
    wr(`OFS_OSC_MODE, 32'h1);
    rd(`OFS_OSC_MODE, 32'h1);
    chk("osc_run", 1, osc_run);
    // Watchdog overflow while still stabilizing
    do_reset(1'b1);
    kick <= 1'b1;
    @(posedge pclk);
    kick <= 1'b0;
    wait_hi(1);
    repeat (20) @(posedge pclk);
    chk("stable", 0, stable);
    rd(`OFS_CLK_STATUS, 32'h1);
    rd(`OFS_IRQ_STATUS, 32'h1);
    wr(`OFS_OSC_MODE, 32'h1);
    rd(`OFS_OSC_MODE, 32'h1);
    chk("osc_run", 1, osc_run);
    chk("cpu_sel", 1, sel_int);
    stop_test();
  end
endmodule
